// ==== rtl/csrm_addr_gen.sv ====
// pointer update for one address generator: linear, circular and bit-reversed
module csrm_addr_gen #(
  parameter bit BREV_OK = 1'b1
) (
  // current pointer and direction
  input wire logic [15:0] ptr,
  input wire logic step_down,
  // circular buffer bounds
  input wire logic mod_en,
  input wire logic [15:0] mod_start,
  input wire logic [15:0] mod_end,
  // bit-reversed stepping
  input wire logic brev_en,
  input wire logic [15:0] brev_mod,
  // updated pointer
  output logic [15:0] next_ptr
);
  logic [15:0] ptr_rev; // pointer with bit order flipped
  logic [15:0] mod_rev; // modifier with bit order flipped
  logic [15:0] sum_rev; // reverse-carry sum
  logic [15:0] brev_ptr;
  logic [15:0] end_word; // last word address inside the buffer
  // flip bit order so an ordinary add carries from msb downward
  for (genvar i = 0; i < 16; i++) begin : g_rev
    assign ptr_rev[i] = ptr[15 - i];
    assign mod_rev[i] = brev_mod[15 - i];
    assign brev_ptr[i] = sum_rev[15 - i];
  end
  assign sum_rev = ptr_rev + mod_rev;
  assign end_word = mod_end & ~16'h0001;
  // choose update kind; bit reversal only where the generator allows it
  always_comb begin
    if (BREV_OK && brev_en && !step_down) begin
      next_ptr = brev_ptr;
    end else if (mod_en && !step_down && ptr >= end_word) begin
      next_ptr = mod_start;
    end else if (mod_en && step_down && ptr <= mod_start) begin
      next_ptr = end_word;
    end else if (step_down) begin
      next_ptr = ptr - csrm_pkg::WORD_STEP;
    end else begin
      next_ptr = ptr + csrm_pkg::WORD_STEP;
    end
  end
endmodule : csrm_addr_gen

// ==== rtl/csrm_ext_addr.sv ====
// forms the extended data address from a base address and page registers
module csrm_ext_addr (
  // base access
  input wire logic [15:0] base_addr,
  input wire logic is_write,
  // page registers
  input wire logic [csrm_pkg::PAGE_W-1:0] rd_page,
  input wire logic [csrm_pkg::PAGE_W-1:0] wr_page,
  input wire logic pwv_en,
  input wire logic [csrm_pkg::PAGE_W-1:0] pwv_page,
  // extended result
  output logic [csrm_pkg::EXT_W-1:0] ext_addr,
  output logic in_program
);
  logic [csrm_pkg::PAGE_W-1:0] page; // page that applies to this access
  always_comb begin
    page = is_write ? wr_page : rd_page;
    in_program = 1'b0;
    if (!base_addr[csrm_pkg::WINDOW_BIT]) begin
      // lower half is always the plain base space
      ext_addr = {{csrm_pkg::PAGE_W{1'b0}}, base_addr[14:0]};
    end else if (pwv_en && !is_write) begin
      // upper half viewed as program memory at a 32 Kbyte boundary
      ext_addr = {pwv_page, base_addr[14:0]};
      in_program = 1'b1;
    end else begin
      ext_addr = {page, base_addr[14:0]};
    end
  end
endmodule : csrm_ext_addr

// ==== rtl/csrm_pkg.sv ====
// constants, register map and field layout for the cpu status and register model
package csrm_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_WREG_BASE = 8'h00; // working registers, one word each
  localparam logic [7:0] OFS_WREG_LAST = 8'h3c;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h44;
  localparam logic [7:0] OFS_RD_PAGE = 8'h48;
  localparam logic [7:0] OFS_WR_PAGE = 8'h4c;
  localparam logic [7:0] OFS_PWV_CTRL = 8'h50;
  localparam logic [7:0] OFS_LOOP_LOW = 8'h54;
  localparam logic [7:0] OFS_LOOP_HIGH = 8'h58;
  localparam logic [7:0] OFS_MOD_START = 8'h5c;
  localparam logic [7:0] OFS_MOD_END = 8'h60;
  localparam logic [7:0] OFS_MOD_CTRL = 8'h64;
  localparam logic [7:0] OFS_BREV_MOD = 8'h68;
  localparam logic [7:0] OFS_NEST_CTRL = 8'h6c;
  // status word bit positions
  localparam int SR_OA = 15;
  localparam int SR_OB = 14;
  localparam int SR_SA = 13;
  localparam int SR_SB = 12;
  localparam int SR_OAB = 11;
  localparam int SR_SAB = 10;
  localparam int SR_DA = 9;
  localparam int SR_DC = 8;
  localparam int SR_IPL_HI = 7;
  localparam int SR_IPL_LO = 5;
  localparam int SR_RA = 4;
  // core control, program window and modulo control fields
  localparam int CC_IPL3 = 3;
  localparam int PWV_EN = 15;
  localparam int MC_X_EN = 0;
  localparam int MC_Y_EN = 1;
  localparam int MC_BREV_EN = 2;
  localparam int MC_XSEL_LO = 4;
  localparam int MC_YSEL_LO = 8;
  // widths and fixed values
  localparam int PAGE_W = 9; // 512 pages of 32 Kbytes: 16 Mbytes reach
  localparam int EXT_W = 24;
  localparam int LOOP_W = 24;
  localparam logic [3:0] SP_IDX = 4'hf; // last working register
  localparam logic [15:0] WORD_STEP = 16'h0002; // byte addressed, word stride
  localparam logic [15:0] WREG_RST = 16'h0000;
  localparam logic [15:0] SR_RST = 16'h0000;
  localparam logic [2:0] IPL_TOP = 3'h7;
  localparam int WINDOW_BIT = 15; // selects the upper 32 Kbytes
  // operand addressing modes
  typedef enum logic [2:0] {
    MODE_INHERENT = 3'h0,
    MODE_RELATIVE = 3'h1,
    MODE_LITERAL = 3'h2,
    MODE_MEM_DIRECT = 3'h3,
    MODE_REG_DIRECT = 3'h4,
    MODE_REG_INDIRECT = 3'h5
  } csrm_mode_t;
endpackage : csrm_pkg

// ==== rtl/csrm_top.sv ====
// working registers, status word, page and address generation state of the cpu core
//
// The address map and register access over APB were left to the implementer.
module csrm_top #(
  parameter bit HAS_DSP = 1'b1 // 0 builds the reduced variant
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core register write port
  input wire logic core_reg_we,
  input wire logic [3:0] core_reg_sel,
  input wire logic [15:0] core_reg_wdata,
  // stack push and pop
  input wire logic stack_push,
  input wire logic stack_pop,
  output logic [15:0] stack_addr,
  output logic stack_valid,
  // operand address requests
  input wire logic agu_req,
  input wire logic [2:0] agu_mode,
  input wire logic agu_write,
  input wire logic agu_dual,
  input wire logic agu_postinc,
  input wire logic agu_dec,
  input wire logic [3:0] agu_x_sel,
  input wire logic [3:0] agu_y_sel,
  input wire logic [15:0] agu_literal,
  output logic agu_valid,
  output logic [23:0] agu_x_ext_addr,
  output logic agu_x_in_program,
  output logic [15:0] agu_y_addr,
  output logic agu_reject,
  // execution unit events
  input wire logic acc_ovf_we,
  input wire logic acc_a_ovf_in,
  input wire logic acc_b_ovf_in,
  input wire logic acc_a_sat_evt,
  input wire logic acc_b_sat_evt,
  input wire logic alu_flags_we,
  input wire logic [4:0] alu_flags_in,
  input wire logic hw_loop_in,
  input wire logic repeat_in,
  input wire logic loop_start_we,
  input wire logic [23:0] loop_start_in,
  // status outputs
  output logic [15:0] cpu_status_word,
  output logic [3:0] cpu_priority_level,
  output logic user_irq_masked
);
  // working register array
  logic [15:0] wreg_r [16];
  // status word pieces
  logic oa_r, ob_r, sa_r, sb_r, dc_r;
  logic [2:0] ipl_r;
  logic [3:0] alu_r; // negative, overflow, zero, carry
  logic da_r, ra_r;
  // control registers
  logic ipl3_r;
  logic nesting_disable_r;
  logic [csrm_pkg::PAGE_W-1:0] ext_read_page_r, ext_write_page_r, pwv_page_r;
  logic pwv_en_r;
  logic [csrm_pkg::LOOP_W-1:0] loop_start_r;
  logic [15:0] mod_start_r, mod_end_r, brev_mod_r;
  logic [11:0] mod_ctrl_r;
  // apb decode
  logic wr_fire, rd_setup;
  logic [15:0] wdat;
  logic wreg_hit;
  logic [31:0] rd_nxt;
  logic rd_err_nxt;
  logic [15:0] sr_view;
  // address generation
  logic [15:0] x_ptr, y_ptr, x_next, y_next, x_base;
  logic x_mod_en, y_mod_en, mode_mem, mode_ok, dual_ok;
  logic [23:0] x_ext;
  logic x_prog;
  // a write takes effect at the access edge
  assign wr_fire = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;
  assign wdat = pwdata[15:0];
  assign wreg_hit = (paddr <= csrm_pkg::OFS_WREG_LAST) && (paddr[1:0] == 2'b00);
  // status word view: combined flags recomputed from their sources
  always_comb begin
    sr_view = csrm_pkg::SR_RST;
    sr_view[csrm_pkg::SR_OA] = oa_r;
    sr_view[csrm_pkg::SR_OB] = ob_r;
    sr_view[csrm_pkg::SR_SA] = sa_r;
    sr_view[csrm_pkg::SR_SB] = sb_r;
    sr_view[csrm_pkg::SR_OAB] = oa_r | ob_r;
    sr_view[csrm_pkg::SR_SAB] = sa_r | sb_r;
    sr_view[csrm_pkg::SR_DA] = da_r;
    sr_view[csrm_pkg::SR_DC] = dc_r;
    sr_view[csrm_pkg::SR_IPL_HI:csrm_pkg::SR_IPL_LO] = ipl_r;
    sr_view[csrm_pkg::SR_RA] = ra_r;
    sr_view[3:0] = alu_r;
  end
  // read mux for the register map
  always_comb begin
    rd_nxt = 32'h0000_0000;
    rd_err_nxt = 1'b0;
    if (wreg_hit) begin
      rd_nxt[15:0] = wreg_r[paddr[5:2]];
    end else begin
      unique case (paddr)
        csrm_pkg::OFS_STATUS: rd_nxt[15:0] = sr_view;
        csrm_pkg::OFS_CORE_CTRL: rd_nxt[csrm_pkg::CC_IPL3] = ipl3_r;
        csrm_pkg::OFS_RD_PAGE: rd_nxt[csrm_pkg::PAGE_W-1:0] = ext_read_page_r;
        csrm_pkg::OFS_WR_PAGE: rd_nxt[csrm_pkg::PAGE_W-1:0] = ext_write_page_r;
        csrm_pkg::OFS_PWV_CTRL: begin
          rd_nxt[csrm_pkg::PWV_EN] = pwv_en_r;
          rd_nxt[csrm_pkg::PAGE_W-1:0] = pwv_page_r;
        end
        csrm_pkg::OFS_LOOP_LOW: rd_nxt[15:0] = loop_start_r[15:0];
        csrm_pkg::OFS_LOOP_HIGH: rd_nxt[7:0] = loop_start_r[23:16];
        csrm_pkg::OFS_MOD_START: rd_nxt[15:0] = mod_start_r;
        csrm_pkg::OFS_MOD_END: rd_nxt[15:0] = mod_end_r;
        csrm_pkg::OFS_MOD_CTRL: rd_nxt[11:0] = mod_ctrl_r;
        csrm_pkg::OFS_BREV_MOD: rd_nxt[15:0] = brev_mod_r;
        csrm_pkg::OFS_NEST_CTRL: rd_nxt[0] = nesting_disable_r;
        default: rd_err_nxt = 1'b1; // unmapped offset
      endcase
    end
  end
  // apb answer: ready and data registered in the setup cycle, one access cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_setup;
      pslverr <= rd_setup & rd_err_nxt;
      if (rd_setup) begin
        prdata <= rd_nxt;
      end
    end
  end
  // working registers: hardware updates win over bus writes to the same register
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        wreg_r[i] <= csrm_pkg::WREG_RST;
      end
    end else begin
      if (wr_fire && wreg_hit) begin
        wreg_r[paddr[5:2]] <= wdat;
      end
      if (core_reg_we) begin
        wreg_r[core_reg_sel] <= core_reg_wdata;
      end
      if (agu_req && mode_ok && agu_postinc && agu_mode == csrm_pkg::MODE_REG_INDIRECT) begin
        wreg_r[agu_x_sel] <= x_next;
        if (dual_ok) begin
          wreg_r[agu_y_sel] <= y_next;
        end
      end
      if (stack_push) begin
        wreg_r[csrm_pkg::SP_IDX] <= wreg_r[csrm_pkg::SP_IDX] + csrm_pkg::WORD_STEP;
      end else if (stack_pop) begin
        wreg_r[csrm_pkg::SP_IDX] <= wreg_r[csrm_pkg::SP_IDX] - csrm_pkg::WORD_STEP;
      end
    end
  end
  // stack access address: push uses the old top, pop the decremented one
  always_ff @(posedge mclk) begin
    if (reset) begin
      stack_addr <= csrm_pkg::WREG_RST;
      stack_valid <= 1'b0;
    end else begin
      stack_valid <= stack_push | stack_pop;
      if (stack_push) begin
        stack_addr <= wreg_r[csrm_pkg::SP_IDX];
      end else if (stack_pop) begin
        stack_addr <= wreg_r[csrm_pkg::SP_IDX] - csrm_pkg::WORD_STEP;
      end
    end
  end
  // accumulator overflow flags: engine update wins over a bus write
  always_ff @(posedge mclk) begin
    if (reset) begin
      oa_r <= 1'b0;
      ob_r <= 1'b0;
    end else if (acc_ovf_we && HAS_DSP) begin
      oa_r <= acc_a_ovf_in;
      ob_r <= acc_b_ovf_in;
    end else if (wr_fire && paddr == csrm_pkg::OFS_STATUS) begin
      // clearing the combined bit clears both sources
      oa_r <= wdat[csrm_pkg::SR_OA] & wdat[csrm_pkg::SR_OAB];
      ob_r <= wdat[csrm_pkg::SR_OB] & wdat[csrm_pkg::SR_OAB];
    end
  end
  // sticky saturation flags: a saturation event beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      sa_r <= 1'b0;
      sb_r <= 1'b0;
    end else begin
      if (wr_fire && paddr == csrm_pkg::OFS_STATUS) begin
        sa_r <= wdat[csrm_pkg::SR_SA] & wdat[csrm_pkg::SR_SAB];
        sb_r <= wdat[csrm_pkg::SR_SB] & wdat[csrm_pkg::SR_SAB];
      end
      if (acc_a_sat_evt && HAS_DSP) begin
        sa_r <= 1'b1;
      end
      if (acc_b_sat_evt && HAS_DSP) begin
        sb_r <= 1'b1;
      end
    end
  end
  // alu result flags and digit carry: alu update wins over a bus write
  always_ff @(posedge mclk) begin
    if (reset) begin
      dc_r <= 1'b0;
      alu_r <= 4'h0;
    end else if (alu_flags_we) begin
      dc_r <= alu_flags_in[4];
      alu_r <= alu_flags_in[3:0];
    end else if (wr_fire && paddr == csrm_pkg::OFS_STATUS) begin
      dc_r <= wdat[csrm_pkg::SR_DC];
      alu_r <= wdat[3:0];
    end
  end
  // loop activity bits follow the sequencer, software cannot write them
  always_ff @(posedge mclk) begin
    if (reset) begin
      da_r <= 1'b0;
      ra_r <= 1'b0;
    end else begin
      da_r <= hw_loop_in & HAS_DSP;
      ra_r <= repeat_in;
    end
  end
  // priority bits writable only while nesting is allowed
  always_ff @(posedge mclk) begin
    if (reset) begin
      ipl_r <= 3'h0;
    end else if (wr_fire && paddr == csrm_pkg::OFS_STATUS && !nesting_disable_r) begin
      ipl_r <= wdat[csrm_pkg::SR_IPL_HI:csrm_pkg::SR_IPL_LO];
    end
  end
  // loop start pair is loaded by the sequencer only; bus writes are dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      loop_start_r <= 24'h00_0000;
    end else if (loop_start_we && HAS_DSP) begin
      loop_start_r <= loop_start_in;
    end
  end
  // control and page registers written from the bus
  always_ff @(posedge mclk) begin
    if (reset) begin
      ipl3_r <= 1'b0;
      nesting_disable_r <= 1'b0;
      ext_read_page_r <= '0;
      ext_write_page_r <= '0;
      pwv_en_r <= 1'b0;
      pwv_page_r <= '0;
      mod_start_r <= 16'h0000;
      mod_end_r <= 16'h0000;
      mod_ctrl_r <= 12'h000;
      brev_mod_r <= 16'h0000;
    end else if (wr_fire) begin
      unique case (paddr)
        csrm_pkg::OFS_CORE_CTRL: ipl3_r <= wdat[csrm_pkg::CC_IPL3];
        csrm_pkg::OFS_NEST_CTRL: nesting_disable_r <= wdat[0];
        csrm_pkg::OFS_RD_PAGE: ext_read_page_r <= wdat[csrm_pkg::PAGE_W-1:0];
        csrm_pkg::OFS_WR_PAGE: ext_write_page_r <= wdat[csrm_pkg::PAGE_W-1:0];
        csrm_pkg::OFS_PWV_CTRL: begin
          pwv_en_r <= wdat[csrm_pkg::PWV_EN];
          pwv_page_r <= wdat[csrm_pkg::PAGE_W-1:0];
        end
        csrm_pkg::OFS_MOD_START: mod_start_r <= wdat;
        csrm_pkg::OFS_MOD_END: mod_end_r <= wdat;
        csrm_pkg::OFS_MOD_CTRL: mod_ctrl_r <= HAS_DSP ? wdat[11:0] : 12'h000;
        csrm_pkg::OFS_BREV_MOD: brev_mod_r <= wdat;
        default: ;
      endcase
    end
  end
  // status and priority outputs
  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_status_word <= csrm_pkg::SR_RST;
      cpu_priority_level <= 4'h0;
      user_irq_masked <= 1'b0;
    end else begin
      cpu_status_word <= sr_view;
      cpu_priority_level <= {ipl3_r, ipl_r};
      user_irq_masked <= ipl3_r | (ipl_r == csrm_pkg::IPL_TOP);
    end
  end
  // operand address formation
  assign x_ptr = wreg_r[agu_x_sel];
  assign y_ptr = wreg_r[agu_y_sel];
  assign mode_mem = (agu_mode == csrm_pkg::MODE_MEM_DIRECT) || (agu_mode == csrm_pkg::MODE_REG_INDIRECT);
  assign mode_ok = (agu_mode <= csrm_pkg::MODE_REG_INDIRECT) && !(agu_dual && !HAS_DSP);
  assign dual_ok = agu_dual && HAS_DSP && agu_mode == csrm_pkg::MODE_REG_INDIRECT;
  assign x_base = (agu_mode == csrm_pkg::MODE_MEM_DIRECT) ? agu_literal : x_ptr;
  assign x_mod_en = HAS_DSP && mod_ctrl_r[csrm_pkg::MC_X_EN]
    && agu_x_sel == mod_ctrl_r[csrm_pkg::MC_XSEL_LO +: 4];
  assign y_mod_en = HAS_DSP && mod_ctrl_r[csrm_pkg::MC_Y_EN]
    && agu_y_sel == mod_ctrl_r[csrm_pkg::MC_YSEL_LO +: 4];
  // x generator: circular and bit-reversed capable
  csrm_addr_gen #(
    .BREV_OK(HAS_DSP)
  ) u_x_gen (
    .ptr(x_ptr),
    .step_down(agu_dec),
    .mod_en(x_mod_en),
    .mod_start(mod_start_r),
    .mod_end(mod_end_r),
    .brev_en(mod_ctrl_r[csrm_pkg::MC_BREV_EN] && !agu_dual && agu_write),
    .brev_mod(brev_mod_r),
    .next_ptr(x_next)
  );
  // y generator: circular only
  csrm_addr_gen #(
    .BREV_OK(1'b0)
  ) u_y_gen (
    .ptr(y_ptr),
    .step_down(agu_dec),
    .mod_en(y_mod_en),
    .mod_start(mod_start_r),
    .mod_end(mod_end_r),
    .brev_en(1'b0),
    .brev_mod(brev_mod_r),
    .next_ptr(y_next)
  );
  // extended and program-window address for the x side
  csrm_ext_addr u_ext (
    .base_addr(x_base),
    .is_write(agu_write),
    .rd_page(ext_read_page_r),
    .wr_page(ext_write_page_r),
    .pwv_en(pwv_en_r),
    .pwv_page(pwv_page_r),
    .ext_addr(x_ext),
    .in_program(x_prog)
  );
  // registered operand address answer, one cycle after the request
  always_ff @(posedge mclk) begin
    if (reset) begin
      agu_valid <= 1'b0;
      agu_reject <= 1'b0;
      agu_x_ext_addr <= 24'h00_0000;
      agu_x_in_program <= 1'b0;
      agu_y_addr <= 16'h0000;
    end else begin
      agu_valid <= agu_req & mode_ok & mode_mem;
      agu_reject <= agu_req & ~mode_ok;
      if (agu_req && mode_ok && mode_mem) begin
        agu_x_ext_addr <= x_ext;
        agu_x_in_program <= x_prog;
        agu_y_addr <= dual_ok ? y_ptr : 16'h0000;
      end
    end
  end
endmodule : csrm_top

// ==== sim/csrm_top_asserts.sv ====
// concurrent checks on the ports of the cpu status and register model
module csrm_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // stack and address generation
  input wire logic stack_push,
  input wire logic stack_valid,
  input wire logic agu_req,
  input wire logic [2:0] agu_mode,
  input wire logic agu_valid,
  input wire logic agu_reject,
  // engine events and status
  input wire logic acc_ovf_we,
  input wire logic acc_a_ovf_in,
  input wire logic acc_a_sat_evt,
  input wire logic hw_loop_in,
  input wire logic [15:0] cpu_status_word,
  input wire logic [3:0] cpu_priority_level,
  input wire logic user_irq_masked
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // setup cycle, then a completed access
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_access) else $error("no access answer");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_stack_ack: assert property (stack_push |=> stack_valid) else $error("push not acknowledged");
  a_agu_memory: assert property (agu_req && (agu_mode == 3'h3 || agu_mode == 3'h5) |=> agu_valid && !agu_reject)
    else $error("memory mode not served");
  a_agu_illegal: assert property (agu_req && agu_mode[2:1] == 2'b11 |=> agu_reject && !agu_valid)
    else $error("illegal mode accepted");
  a_ovf_or: assert property (cpu_status_word[11] == (cpu_status_word[15] || cpu_status_word[14]))
    else $error("combined overflow wrong");
  a_sat_sticky: assert property (acc_a_sat_evt |=> ##1 (cpu_status_word[13] && cpu_status_word[10]))
    else $error("saturation flag not set");
  a_ovf_load: assert property (acc_ovf_we |=> ##1 cpu_status_word[15] == $past(acc_a_ovf_in, 2))
    else $error("overflow flag not loaded");
  a_loop_flag: assert property (!reset ##1 !reset |=> cpu_status_word[9] == $past(hw_loop_in, 2))
    else $error("loop flag wrong");
  a_irq_mask: assert property (user_irq_masked == (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
    else $error("mask wrong");
endmodule : csrm_chk

bind csrm_top csrm_chk csrm_chk_inst (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .stack_push(stack_push), .stack_valid(stack_valid), .agu_req(agu_req),
  .agu_mode(agu_mode), .agu_valid(agu_valid), .agu_reject(agu_reject), .acc_ovf_we(acc_ovf_we),
  .acc_a_ovf_in(acc_a_ovf_in), .acc_a_sat_evt(acc_a_sat_evt), .hw_loop_in(hw_loop_in),
  .cpu_status_word(cpu_status_word), .cpu_priority_level(cpu_priority_level), .user_irq_masked(user_irq_masked));

// ==== sim/tb_top.sv ====
// self-checking bench for the cpu status and register model
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // bench-driven inputs
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, core_reg_we = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] core_reg_sel = 0, agu_x_sel = 0, agu_y_sel = 0, cpu_priority_level;
  logic [15:0] core_reg_wdata = 0, agu_literal = 0, stack_addr, agu_y_addr, cpu_status_word;
  logic stack_push = 0, stack_pop = 0, agu_req = 0, agu_write = 0, agu_dual = 0, agu_postinc = 0, agu_dec = 0;
  logic [2:0] agu_mode = 0;
  logic [23:0] agu_x_ext_addr, loop_start_in = 0;
  logic acc_ovf_we = 0, acc_a_ovf_in = 0, acc_b_ovf_in = 0, acc_a_sat_evt = 0, acc_b_sat_evt = 0;
  logic alu_flags_we = 0, hw_loop_in = 0, repeat_in = 0, loop_start_we = 0;
  logic [4:0] alu_flags_in = 0;
  // design outputs and bench state
  logic pready, pslverr, stack_valid, agu_valid, agu_x_in_program, agu_reject, user_irq_masked, er;
  int bad_count = 0, n_checks = 0, cyc = 0;
  // one table row: offset, write value, read back, error expected
  typedef struct {logic [7:0] a; logic [15:0] w; logic [15:0] e; logic r;} csrm_row_t;
  csrm_row_t rows [14] = '{'{8'h40, 16'h0000, 16'h0000, 0}, '{8'h00, 16'h1234, 16'h1234, 0},
    '{8'h3c, 16'hbeef, 16'hbeef, 0}, '{8'h48, 16'hffff, 16'h01ff, 0}, '{8'h4c, 16'h0155, 16'h0155, 0},
    '{8'h54, 16'hffff, 16'hcdef, 0}, '{8'h58, 16'hffff, 16'h00ab, 0}, '{8'h40, 16'hffff, 16'hfdef, 0},
    '{8'h40, 16'h3400, 16'h3400, 0}, '{8'h40, 16'h2000, 16'h0000, 0}, '{8'h40, 16'h00e0, 16'h00e0, 0},
    '{8'h6c, 16'h0001, 16'h0001, 0}, '{8'h40, 16'h0000, 16'h00e0, 0}, '{8'h70, 16'h1111, 16'h0000, 1}};
  csrm_top csrm_top_inst (.*);
  // 125 MHz clock
  always #4 mclk = ~mclk;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // core write port
  task automatic wreg(input logic [3:0] s, input logic [15:0] v);
    @(posedge mclk);
    core_reg_we <= 1;
    core_reg_sel <= s;
    core_reg_wdata <= v;
    @(posedge mclk);
    core_reg_we <= 0;
  endtask : wreg
  // one operand address request, answer settled on return
  task automatic address_generator(input logic [2:0] m, input logic w, input logic d, input logic dn, input logic [15:0] lit);
    @(posedge mclk);
    {agu_req, agu_mode, agu_write, agu_dual, agu_dec, agu_literal} <= {1'b1, m, w, d, dn, lit};
    @(posedge mclk);
    agu_req <= 0;
    #1;
  endtask : address_generator
  // counts and verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 0;
    apb(0, 8'h40, 0);
    chk("status at reset", rd, 0);
    // engine events all at one edge
    @(posedge mclk);
    {acc_ovf_we, acc_a_ovf_in, acc_a_sat_evt, acc_b_sat_evt, alu_flags_we, loop_start_we} <= 6'h3f;
    {alu_flags_in, loop_start_in, hw_loop_in, repeat_in} <= {5'h1f, 24'habcdef, 2'b11};
    @(posedge mclk);
    {acc_ovf_we, acc_a_sat_evt, acc_b_sat_evt, alu_flags_we, loop_start_we} <= 5'h00;
    apb(0, 8'h40, 0);
    chk("status events", rd, 32'h0000bf1f);
    hw_loop_in <= 0;
    repeat_in <= 0;
    // table of write then read back
    foreach (rows[i]) begin
      apb(1, rows[i].a, {16'h0000, rows[i].w});
      apb(0, rows[i].a, 0);
      chk("read back", rd, {16'h0000, rows[i].e});
      chk("slave error", er, rows[i].r);
    end
    chk("priority", {user_irq_masked, cpu_priority_level}, 5'h17);
    // saturation event on the access edge of a clearing status write: the event wins
    fork
      apb(1, 8'h40, 0);
      begin
        repeat (2) @(posedge mclk);
        acc_a_sat_evt <= 1;
        @(posedge mclk);
        acc_a_sat_evt <= 0;
      end
    join
    apb(0, 8'h40, 0);
    chk("event beats clear", rd, 32'h000024e0);
    // push then pop on the stack pointer
    wreg(4'hf, 16'h1000);
    stack_push <= 1;
    @(posedge mclk);
    stack_push <= 0;
    stack_pop <= 1;
    #1 chk("push", {stack_valid, stack_addr}, 17'h11000);
    @(posedge mclk);
    stack_pop <= 0;
    #1 chk("pop", {stack_valid, stack_addr}, 17'h11000);
    // every operand mode through the x generator
    wreg(4'h2, 16'h0100);
    for (int m = 0; m < 8; m++) begin
      @(posedge mclk);
      {agu_req, agu_mode, agu_x_sel, agu_postinc, agu_literal} <= {1'b1, 3'(m), 4'h2, 1'b1, 16'h8004};
      @(posedge mclk);
      agu_req <= 0;
      #1 chk("mode answer", {agu_valid, agu_reject}, {m == 3 || m == 5, m > 5});
      if (m == 3)
        chk("paged address", agu_x_ext_addr, 24'hff8004);
      if (m == 5)
        chk("indirect address", agu_x_ext_addr, 24'h000100);
    end
    apb(0, 8'h08, 0);
    chk("post increment", rd, 32'h00000102);
    // lower half, program window read and paged write on the x side
    apb(1, 8'h50, 32'h00008003);
    address_generator(3'h3, 1'b0, 1'b0, 1'b0, 16'h7ffe);
    chk("base address", {agu_x_in_program, agu_x_ext_addr}, 25'h0007ffe);
    address_generator(3'h3, 1'b0, 1'b0, 1'b0, 16'h8004);
    chk("window read", {agu_x_in_program, agu_x_ext_addr}, 25'h1018004);
    address_generator(3'h3, 1'b1, 1'b0, 1'b0, 16'h8004);
    chk("paged write", {agu_x_in_program, agu_x_ext_addr}, 25'h0aa8004);
    // dual operand fetch through both generators
    agu_y_sel <= 4'h3;
    wreg(4'h3, 16'h0200);
    address_generator(3'h5, 1'b0, 1'b1, 1'b0, 16'h0000);
    chk("dual y", {agu_valid, agu_y_addr}, 17'h10200);
    chk("dual x", agu_x_ext_addr, 24'h000102);
    apb(0, 8'h0c, 0);
    chk("y post increment", rd, 32'h00000202);
    // circular buffer 0x0100..0x0104 on w2, wrap upward then downward
    apb(1, 8'h5c, 32'h00000100);
    apb(1, 8'h60, 32'h00000105);
    apb(1, 8'h64, 32'h00000021);
    address_generator(3'h5, 1'b0, 1'b0, 1'b0, 16'h0000);
    apb(0, 8'h08, 0);
    chk("modulo wrap up", rd, 32'h00000100);
    address_generator(3'h5, 1'b0, 1'b0, 1'b1, 16'h0000);
    apb(0, 8'h08, 0);
    chk("modulo wrap down", rd, 32'h00000104);
    // bit-reversed step of 0x0004 from 0x0104 carries downward to 0x0102
    apb(1, 8'h68, 32'h00000004);
    apb(1, 8'h64, 32'h00000004);
    address_generator(3'h5, 1'b1, 1'b0, 1'b0, 16'h0000);
    apb(0, 8'h08, 0);
    chk("bit reverse", rd, 32'h00000102);
    // mid-run reset clears the status and priority outputs, w2 and the program window register
    @(posedge mclk);
    reset <= 1;
    repeat (2) @(posedge mclk);
    reset <= 0;
    #1 chk("reset outputs", {user_irq_masked, cpu_priority_level, cpu_status_word}, 0);
    apb(0, 8'h08, 0);
    chk("reset pointer", rd, 0);
    apb(0, 8'h50, 0);
    chk("reset window", rd, 0);
    print_verdict();
  end
endmodule : tb_top
